// *** common/acsd_pkg.sv ***
// Purpose: Shared constants and types for the command decoder
// Assumes: Serial port mode byte framing, eight bits MSB first
// Notes:   Channel-setup chain holds eight logical entries max
package acsd_pkg;
  // ----------------------------------------------------------------
  // Command byte fields
  // ----------------------------------------------------------------
  localparam int CMD_SET_BIT   = 7;
  localparam int CMD_ZERO_BIT  = 6;
  localparam int CMD_RW_BIT    = 3;
  localparam logic [2:0] REG_OFFSET = 3'h1;
  localparam logic [2:0] REG_GAIN   = 3'h2;
  localparam logic [2:0] REG_CONFIG = 3'h3;
  localparam logic [2:0] REG_FIFO   = 3'h4;
  localparam logic [2:0] REG_SETUP  = 3'h5;
  localparam logic [2:0] OP_CONV    = 3'h0;
  localparam logic [2:0] OP_SOFFS   = 3'h1;
  localparam logic [2:0] OP_SGAIN   = 3'h2;
  localparam logic [2:0] OP_YOFFS   = 3'h5;
  localparam logic [2:0] OP_YGAIN   = 3'h6;
  // ----------------------------------------------------------------
  // Channel-setup layout
  // ----------------------------------------------------------------
  localparam int ENTRY_W       = 12;
  localparam int NUM_ENTRIES   = 8;
  localparam int SETUP_BITS_2  = 48;
  localparam int SETUP_BITS_4  = 96;
  localparam logic [11:0] ENTRY_RESET = 12'h000;
  localparam int MAX_PERIOD_W  = 15;
  // Word rate periods in crystal cycles
  localparam logic [14:0] WR_PERIOD [8] = '{15'h0884, 15'h0444,
    15'h0214, 15'h0184, 15'h0144, 15'h4424, 15'h2214, 15'h110C};
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] latch;
    logic       zero;
    logic [1:0] physSel;
    logic [2:0] wordRate;
    logic [2:0] gainRange;
    logic       unipolar;
  } acsd_entry_t;

  typedef struct packed {
    logic       valid;
    logic       isWrite;
    logic [2:0] regCode;
    logic [1:0] physChanAddr;
    logic [6:0] bitCount;
  } acsd_access_t;

  typedef struct packed {
    logic       valid;
    logic       isCal;
    logic [2:0] opCode;
    logic [2:0] logicalChan;
  } acsd_operation_t;

  typedef struct packed {
    logic multiConversion;
    logic loopFlag;
    logic readBeforeConvert;
  } acsd_flags_t;

  typedef enum logic [1:0] {
    ACSD_CMD  = 2'b00,
    ACSD_DATA = 2'b01
  } acsd_mode_t;
endpackage : acsd_pkg

// *** hw/acsd_setup_mem.sv ***
// Purpose: Channel-setup storage, eight 12-bit logical entries
// Assumes: One write port, registered read data
// Notes:   Reset value of every entry is all zero
`timescale 1ns/100ps
`default_nettype none
module acsd_setup_mem
  import acsd_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Write port
  input  wire logic        wrEn,
  input  wire logic [2:0]  wrAddr,
  input  wire logic [11:0] wrData,
  // Read port
  input  wire logic [2:0]  rdAddr,
  output var  logic [11:0] rdData
);
  typedef struct packed {
    logic [NUM_ENTRIES-1:0][11:0] entry;
    logic [11:0]                  rd;
  } acsd_mem_state_t;

  acsd_mem_state_t state;
  acsd_mem_state_t next_state;

  always_comb begin
    next_state = state;
    next_state.rd = state.entry[rdAddr];
    for (int i = 0; i < NUM_ENTRIES; i++) begin
      if (wrEn && wrAddr == 3'(i)) begin
        next_state.entry[i] = wrData;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign rdData = state.rd;
endmodule : acsd_setup_mem
`default_nettype wire

// *** hw/acsd_command_decode.sv ***
// Purpose: Serial command byte decoder and channel-setup registers
// Assumes: Host drives serial clock; sampled here on clk
// Notes:   Other registers live outside; every data bit shifts, only setup data is stored here
//
// Operation
// - MSB zero means register access command
// - Channel address picks calibration set, not FIFO
// - Direction bit zero writes, one reads
// - Register select decode, reserved codes ignored
// - Setup access moves 48 or 96 bits
// - MSB one means conversion or calibration
// - Conversion pointer used only when multi flag clear; calibrations always use it
// - Operation code decode, reserved codes ignored
// - Two entries per register, first in MSBs
// - Latch pins follow active entry top bits in command mode only; they hold through data mode
// - Physical select codes pick inputs one-four
// - Word rate sets conversion period
// - Gain field selects input range
// - Polarity bit zero bipolar, one unipolar
// - Non-calibration commands enter data mode
`timescale 1ns/100ps
`default_nettype none
module acsd_command_decode
  import acsd_pkg::*;
#(
  parameter bit FOUR_CHANNEL = 1'b1
)
(
  // Clock and reset
  input  wire logic            clk,
  input  wire logic            rst_n,
  // Serial port pins
  input  wire logic            chipSelect_n,
  input  wire logic            serialClock,
  input  wire logic            serialDataIn,
  output logic                 serialDataOut,
  output logic                 serialDataOutEn,
  // Configuration flags from the configuration register
  input  wire acsd_flags_t     cfgFlags,
  input  wire logic [2:0]      activeEntry,
  // Decoded requests
  output acsd_access_t         accessReq,
  output acsd_operation_t      operationReq,
  output acsd_flags_t          effFlags,
  // Active entry decode
  output logic [1:0]           latchOut,
  output logic [1:0]           physInput,
  output logic [14:0]          convPeriod,
  output logic [2:0]           gainRange,
  output logic                 unipolar
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0]      csSync;
    logic [1:0]      sclkSync;
    logic [1:0]      sdiSync;
    logic            sclkPrev;
    acsd_mode_t      mode;
    logic [7:0]      shiftIn;
    logic [3:0]      bitCnt;
    logic [6:0]      dataLeft;
    logic            dataWrite;
    logic [11:0]     entryShift;
    logic [3:0]      entryBit;
    logic [2:0]      entryIdx;
    logic            sdo;
    acsd_access_t    access;
    acsd_operation_t operation;
    acsd_flags_t     flags;
    logic [11:0]     active;
  } acsd_state_t;

  acsd_state_t state;
  acsd_state_t next_state;
  logic        memWrEn;
  logic [2:0]  memRdAddr;
  logic [11:0] memRdData;
  logic        rise;
  logic        fall;
  logic        csActive;
  logic [7:0]  cmd;
  logic [6:0]  setupBits;

  assign setupBits = FOUR_CHANNEL ? 7'(SETUP_BITS_4) : 7'(SETUP_BITS_2);
  assign rise     = state.sclkSync[1] & ~state.sclkPrev;
  assign fall     = ~state.sclkSync[1] & state.sclkPrev;
  assign csActive = ~state.csSync[1];
  assign cmd      = {state.shiftIn[6:0], state.sdiSync[1]};
  assign memWrEn  = state.mode == ACSD_DATA && rise && csActive
                    && state.dataWrite && state.entryBit == 4'hB;
  assign memRdAddr = (state.mode == ACSD_DATA) ? state.entryIdx
                                               : activeEntry;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_state.csSync   = {state.csSync[0], chipSelect_n};
    next_state.sclkSync = {state.sclkSync[0], serialClock};
    next_state.sdiSync  = {state.sdiSync[0], serialDataIn};
    next_state.sclkPrev = state.sclkSync[1];
    next_state.access.valid    = 1'b0;
    next_state.operation.valid = 1'b0;
    if (state.mode == ACSD_CMD) begin
      next_state.active = memRdData;
    end
    if (!csActive) begin
      next_state.bitCnt = 4'h0;
    end else if (state.mode == ACSD_CMD && rise) begin
      next_state.shiftIn = cmd;
      next_state.bitCnt  = state.bitCnt + 4'h1;
      if (state.bitCnt == 4'h7) begin
        next_state.bitCnt = 4'h0;
        if (!cmd[CMD_SET_BIT]) begin
          // Bit six is trusted to be zero; not checked
          if (cmd[2:0] inside {REG_OFFSET, REG_GAIN, REG_CONFIG,
                               REG_FIFO, REG_SETUP}) begin
            next_state.access.valid   = 1'b1;
            next_state.access.isWrite = ~cmd[CMD_RW_BIT];
            next_state.access.regCode = cmd[2:0];
            next_state.access.physChanAddr =
              (cmd[2:0] == REG_FIFO) ? 2'h0 : cmd[5:4];
            next_state.access.bitCount =
              (cmd[2:0] == REG_SETUP) ? setupBits : 7'd24;
            next_state.mode = ACSD_DATA;
            next_state.dataLeft = (cmd[2:0] == REG_SETUP) ? setupBits
                                                          : 7'd24;
            next_state.dataWrite = ~cmd[CMD_RW_BIT]
                                   && cmd[2:0] == REG_SETUP;
            next_state.entryIdx  = 3'h0;
            next_state.entryBit  = 4'h0;
          end
        end else if (cmd[2:0] inside {OP_CONV, OP_SOFFS, OP_SGAIN,
                                      OP_YOFFS, OP_YGAIN}) begin
          next_state.operation.valid = 1'b1;
          next_state.operation.opCode = cmd[2:0];
          next_state.operation.isCal  = cmd[2:0] != OP_CONV;
          // Calibrations ignore the multi flag, so their pointer holds
          next_state.operation.logicalChan =
            (cfgFlags.multiConversion && cmd[2:0] == OP_CONV)
            ? 3'h0 : cmd[5:3];
          if (cmd[2:0] != OP_CONV) begin
            next_state.flags = '0;
          end else begin
            next_state.flags = cfgFlags;
            next_state.mode  = ACSD_DATA;
            next_state.dataLeft  = 7'd24;
            next_state.dataWrite = 1'b0;
          end
        end
      end
    end else if (state.mode == ACSD_DATA) begin
      if (rise) begin
        next_state.entryShift = {state.entryShift[10:0],
                                 state.sdiSync[1]};
        next_state.entryBit   = state.entryBit + 4'h1;
        if (state.entryBit == 4'hB) begin
          next_state.entryBit = 4'h0;
          next_state.entryIdx = state.entryIdx + 3'h1;
        end
        next_state.dataLeft = state.dataLeft - 7'h1;
        if (state.dataLeft == 7'h1) begin
          next_state.mode = ACSD_CMD;
        end
      end
      if (fall && state.access.regCode == REG_SETUP) begin
        next_state.sdo = memRdData[4'hB - state.entryBit];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state          <= '0;
      state.csSync   <= 2'b11;
      state.mode     <= ACSD_CMD;
      state.active   <= ENTRY_RESET;
    end else begin
      state <= next_state;
    end
  end

  acsd_setup_mem u_mem (
    .clk    (clk),
    .rst_n  (rst_n),
    .wrEn   (memWrEn),
    .wrAddr (state.entryIdx),
    .wrData ({state.entryShift[10:0], state.sdiSync[1]}),
    .rdAddr (memRdAddr),
    .rdData (memRdData)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign serialDataOut   = state.sdo;
  assign serialDataOutEn = csActive;
  assign accessReq       = state.access;
  assign operationReq    = state.operation;
  assign effFlags        = state.flags;
  assign latchOut   = state.active[11:10];
  assign physInput  = state.active[8:7];
  assign convPeriod = WR_PERIOD[state.active[6:4]];
  assign gainRange  = state.active[3:1];
  assign unipolar   = state.active[0];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_cal_flags: assert property (@(posedge clk) disable iff (!rst_n)
    operationReq.valid && operationReq.isCal |-> effFlags == '0)
    else $error("calibration kept flags");
  chk_reserved_idle: assert property (@(posedge clk) disable iff (!rst_n)
    state.mode == ACSD_CMD && rise && csActive && state.bitCnt == 4'h7
    && !cmd[7] && cmd[2:0] inside {3'h0, 3'h6, 3'h7}
    |=> state.mode == ACSD_CMD && !accessReq.valid)
    else $error("reserved code acted");
  chk_write_dir: assert property (@(posedge clk) disable iff (!rst_n)
    accessReq.valid |-> accessReq.isWrite == ~state.shiftIn[CMD_RW_BIT])
    else $error("direction wrong");
  chk_fifo_addr: assert property (@(posedge clk) disable iff (!rst_n)
    accessReq.valid && accessReq.regCode == REG_FIFO
    |-> accessReq.physChanAddr == 2'h0)
    else $error("fifo address used");
  chk_setup_len: assert property (@(posedge clk) disable iff (!rst_n)
    accessReq.valid && accessReq.regCode == REG_SETUP
    |-> state.dataLeft == setupBits)
    else $error("setup length wrong");
  chk_data_mode: assert property (@(posedge clk) disable iff (!rst_n)
    accessReq.valid |-> state.mode == ACSD_DATA)
    else $error("no data mode");
  chk_pointer_mc: assert property (@(posedge clk) disable iff (!rst_n)
    operationReq.valid && !operationReq.isCal
    && $past(cfgFlags.multiConversion)
    |-> operationReq.logicalChan == 3'h0)
    else $error("pointer used in multi mode");
  chk_cal_pointer: assert property (@(posedge clk) disable iff (!rst_n)
    operationReq.valid && operationReq.isCal
    |-> operationReq.logicalChan == state.shiftIn[5:3])
    else $error("calibration pointer dropped");
  chk_cal_cmd_mode: assert property (@(posedge clk) disable iff (!rst_n)
    operationReq.valid && operationReq.isCal |-> state.mode == ACSD_CMD)
    else $error("calibration entered data mode");
  chk_latch_follow: assert property (@(posedge clk) disable iff (!rst_n)
    state.mode == ACSD_CMD
    |=> latchOut == $past(memRdData[11:10]))
    else $error("latch not following entry");
endmodule : acsd_command_decode
`default_nettype wire

// *** verification/acsd_host_model.sv ***
// Purpose: Host controller model on the converter serial port
// Assumes: Clock idles low, 125 ns bit period, data taken on rise
// Notes:   A released data line shows the inverse of its last bit
`timescale 1ns/100ps
`default_nettype none
module acsd_host_model (
  // Serial port pins
  output var  logic chipSelect_n,
  output var  logic serialClock,
  output var  logic serialDataIn,
  input  wire logic serialDataOut
);
  initial begin
    chipSelect_n = 1'b1;
    serialClock  = 1'b0;
    serialDataIn = 1'b1;
  end
  // Shift n bits MSB first; clock stands still outside frames
  task automatic xfer(input logic [95:0] tx, input int n,
                      output logic [95:0] rx);
    rx = '0;
    chipSelect_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      serialDataIn = tx[i];
      #62.5 serialClock = 1'b1;
      rx[i] = serialDataOut;
      #62.5 serialClock = 1'b0;
    end
  endtask : xfer
  // Chip select high ends the frame; the released line shows the inverse
  task automatic idle;
    chipSelect_n = 1'b1;
    serialDataIn = ~serialDataIn;
    #250;
  endtask : idle
endmodule : acsd_host_model
`default_nettype wire

// *** verification/tb_top.sv ***
// Purpose: Self-checking bench for the command decoder
// Assumes: Four-channel variant, host model drives the serial pins
// Notes:   Reserved codes are checked by a missing request pulse
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, gt) begin checksDone++; if ((gt) !== (ex)) begin \
  miscompares++; $display("FAIL %s exp %0h got %0h", nm, ex, gt); end end
module tb_top;
  import acsd_pkg::*;
  typedef struct packed {
    logic [7:0] cmd; acsd_flags_t flg; logic [6:0] nData;
    logic acc; logic op; logic [7:0] fld; acsd_flags_t eff;
  } acsd_row_t;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk = 1'b0, rst_n = 1'b0, sdo, sdoEn, csN, sclk, sdi;
  acsd_flags_t     cfgFlags = '0, effFlags;
  logic [2:0]      activeEntry = '0, gainRange;
  acsd_access_t    accessReq, accCap;
  acsd_operation_t operationReq, opCap;
  logic [1:0]      latchOut, physInput;
  logic [14:0]     convPeriod;
  logic            unipolar;
  logic [95:0]     rx, chain;
  acsd_entry_t     ent;
  int miscompares = 0, checksDone = 0, accCnt = 0, opCnt = 0, a0, o0;
  int period [8] = '{2180, 1092, 532, 388, 324, 17444, 8724, 4364};
  acsd_row_t rows [15] = '{
    '{8'h01, 3'h0, 7'h18, 1'b1, 1'b0, 8'h24, 3'h0},
    '{8'h1A, 3'h0, 7'h18, 1'b1, 1'b0, 8'h09, 3'h0},
    '{8'h2B, 3'h0, 7'h18, 1'b1, 1'b0, 8'h0E, 3'h0},
    '{8'h0C, 3'h0, 7'h18, 1'b1, 1'b0, 8'h10, 3'h0},
    '{8'h30, 3'h0, 7'h00, 1'b0, 1'b0, 8'h00, 3'h0},
    '{8'h06, 3'h0, 7'h00, 1'b0, 1'b0, 8'h00, 3'h0},
    '{8'h0F, 3'h0, 7'h00, 1'b0, 1'b0, 8'h00, 3'h0},
    '{8'h80, 3'h3, 7'h18, 1'b0, 1'b1, 8'h00, 3'h3},
    '{8'hB8, 3'h0, 7'h18, 1'b0, 1'b1, 8'h07, 3'h0},
    '{8'h89, 3'h7, 7'h00, 1'b0, 1'b1, 8'h49, 3'h0},
    '{8'h92, 3'h7, 7'h00, 1'b0, 1'b1, 8'h52, 3'h0},
    '{8'h9D, 3'h7, 7'h00, 1'b0, 1'b1, 8'h6B, 3'h0},
    '{8'hA6, 3'h7, 7'h00, 1'b0, 1'b1, 8'h74, 3'h0},
    '{8'hA0, 3'h4, 7'h18, 1'b0, 1'b1, 8'h00, 3'h4},
    '{8'h84, 3'h0, 7'h00, 1'b0, 1'b0, 8'h00, 3'h0}
  };
  // ----------------------------------------------------------------
  // Design, host and request capture
  // ----------------------------------------------------------------
  acsd_command_decode u_dut (.clk(clk), .rst_n(rst_n),
    .chipSelect_n(csN), .serialClock(sclk), .serialDataIn(sdi),
    .serialDataOut(sdo), .serialDataOutEn(sdoEn), .cfgFlags(cfgFlags),
    .activeEntry(activeEntry), .accessReq(accessReq),
    .operationReq(operationReq), .effFlags(effFlags),
    .latchOut(latchOut), .physInput(physInput), .convPeriod(convPeriod),
    .gainRange(gainRange), .unipolar(unipolar));
  acsd_host_model u_host (.chipSelect_n(csN), .serialClock(sclk),
    .serialDataIn(sdi), .serialDataOut(sdo));
  always #4 clk = ~clk;
  always @(posedge clk) begin
    if (accessReq.valid === 1'b1) begin
      accCnt++;
      accCap = accessReq;
    end
    if (operationReq.valid === 1'b1) begin
      opCnt++;
      opCap = operationReq;
    end
  end
  task automatic stopTest;
    $display("checks %0d miscompares %0d", checksDone, miscompares);
    if (miscompares == 0 && checksDone > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stopTest
  // Whole run is near 70 us; a hang is cut at 250 us
  initial begin
    #250000;
    miscompares++;
    stopTest();
  end
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    `CHK("latchOut", 2'h0, latchOut)
    `CHK("sdoEn", 1'b0, sdoEn)
    $display("test reset done");
    foreach (rows[k]) begin
      @(negedge clk) cfgFlags = rows[k].flg;
      a0 = accCnt;
      o0 = opCnt;
      u_host.xfer({88'h0, rows[k].cmd}, 8, rx);
      if (rows[k].nData != 0) u_host.xfer({96{1'b1}}, rows[k].nData, rx);
      u_host.idle();
      `CHK("acc", int'(rows[k].acc), accCnt - a0)
      `CHK("op", int'(rows[k].op), opCnt - o0)
      if (rows[k].acc) begin
        `CHK("accF", rows[k].fld[5:0],
          {accCap.isWrite, accCap.regCode, accCap.physChanAddr})
        `CHK("bits", rows[k].nData, accCap.bitCount)
      end
      if (rows[k].op) begin
        `CHK("opF", rows[k].fld[6:0],
          {opCap.isCal, opCap.opCode, opCap.logicalChan})
        `CHK("eff", rows[k].eff, effFlags)
      end
      $display("test row %0d done", k);
    end
    // Reserved operation then a valid one in the same frame
    o0 = opCnt;
    u_host.xfer(96'h8781, 16, rx);
    u_host.idle();
    `CHK("opRes", 1, opCnt - o0)
    `CHK("opCode", OP_SOFFS, opCap.opCode)
    $display("test reserved-then-valid done");
    // Eight entries written as one chain, first entry in the MSBs
    for (int e = 0; e < 8; e++) begin
      ent = '{e[1:0], 1'b0, ~e[1:0], e[2:0], 3'(e % 6), e[0]};
      chain[95 - 12 * e -: 12] = ent;
    end
    u_host.xfer(96'h05, 8, rx);
    u_host.xfer(chain, 96, rx);
    u_host.idle();
    `CHK("setupReg", REG_SETUP, accCap.regCode)
    `CHK("setupBits", 7'(SETUP_BITS_4), accCap.bitCount)
    for (int e = 0; e < 8; e++) begin
      @(negedge clk) activeEntry = 3'(e);
      repeat (4) @(negedge clk);
      ent = chain[95 - 12 * e -: 12];
      `CHK("latch", ent.latch, latchOut)
      `CHK("phys", ent.physSel, physInput)
      `CHK("period", 15'(period[e]), convPeriod)
      `CHK("gain", ent.gainRange, gainRange)
      `CHK("unipolar", ent.unipolar, unipolar)
    end
    u_host.xfer(96'h0D, 8, rx);
    u_host.xfer(96'h0, 96, rx);
    `CHK("sdoEn", 1'b1, sdoEn)
    u_host.idle();
    `CHK("readBack", chain, rx)
    $display("test setup chain done");
    // Reset in mid-run returns active entry 7 and the latch pins to zero
    @(negedge clk) rst_n = 1'b0;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    `CHK("rstLatch", 2'h0, latchOut)
    `CHK("rstPeriod", 15'(period[0]), convPeriod)
    o0 = opCnt;
    u_host.xfer(96'h82, 8, rx);
    u_host.idle();
    `CHK("rstOp", 1, opCnt - o0)
    `CHK("rstCode", OP_SGAIN, opCap.opCode)
    $display("test mid reset done");
    stopTest();
  end
endmodule : tb_top
`undef CHK
`default_nettype wire
